// ===== logic/ctrl_port_pkg.sv
// Constants, register map and carrier types for the codec control-port host.
package ctrl_port_pkg;

  // ----------------------------------------------------------------
  // Host register map (index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h5;

  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_PAGE = 3;

  // Reset values
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Codec-side register space and serial formats
  // ----------------------------------------------------------------
  localparam logic [6:0] PAGE_SELECT_ADDR = 7'h00;
  localparam logic [4:0] I2C_ADDR_HI = 5'h06;
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [7:0] I2C_RELEASE = 8'hFF;
  localparam logic [7:0] SPI_DUMMY = 8'h00;
  localparam logic [6:0] TX_PAD = 7'h00;
  localparam logic [4:0] SPI_LAST_BIT = 5'h0F;
  localparam logic [4:0] I2C_LAST_BIT = 5'h08;
  localparam logic [1:0] IDX_DEV_WR = 2'h0;
  localparam logic [1:0] IDX_REG = 2'h1;
  localparam logic [1:0] IDX_THIRD = 2'h2;
  localparam logic [1:0] IDX_RD_DATA = 2'h3;
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_MID = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_NS = 10;
  localparam int RESET_RAW_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC = (RESET_RAW_CYC < 1) ? 1 : RESET_RAW_CYC;
  localparam logic [6:0] RESET_HOLD_LIM = 7'(RESET_HOLD_CYC - 1);
  localparam int SS_GAP_NS = 6250;
  localparam int SS_GAP_CYC = (SS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] SS_GAP_LIM = 7'(SS_GAP_CYC - 1);
  // Quarter-bit lengths in ref_clk cycles (SPI 800 ns bit, I2C 2.8 us bit)
  localparam logic [3:0] SPI_QTR_LIM = 4'h1;
  localparam logic [3:0] I2C_QTR_LIM = 4'h6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic gcall;
    logic adr1;
    logic adr0;
    logic spi;
  } cfg_t;

endpackage

// ===== logic/dual_serial_host.sv
// Host controller driving the codec control port over SPI or I2C.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Function
// R01: SPI clock idles low, host masters frames
// R02: MOSI changes on first clock edge
// R03: Device returns MISO byte while receiving
// R04: First byte after select fall is command
// R05: Command holds address 7:1, direction bit 0
// R06: Write: direction 0, then data byte
// R07: Read: data returns in second byte
// R08: Address 0 selects the active page
// R09: Only two pages; page 0 after reset
// R10: 0x01 selects page 1, 0x00 page 0
// R11: Keep select high 6.25 us between writes
// R12: Raising select ends a burst
// R13: Never burst past a page end
// R14: Strap low selects 7-bit I2C slave
// R15: I2C address 00110 plus two straps
// R16: I2C lines only pulled low or released
// R17: START/STOP are SDA edges, SCL high
// R18: Slave acknowledges addressed bytes, ninth clock
// R19: General call address zero is acknowledged
// R20: Further write bytes auto-increment register
// R21: Master acknowledge continues the read burst
// R22: Reserved bits written with default values
// R23: Strap high selects SPI, kept stable
// R24: Codec reset low 10 ns before access
// R25: All bytes shift MSB first
// R26: Master NACK ends read, SDA released
// ------------------------------------------------------------------
module dual_serial_host (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire ctrl_port_pkg::bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic select_strap,
  output logic codec_reset_n,
  output logic multifunction_pin_a,
  output logic multifunction_pin_b,
  input wire logic multifunction_pin_c,
  output logic multifunction_pin_d,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import ctrl_port_pkg::*;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum {
    ST_RESET, ST_IDLE, ST_SPI_BIT, ST_SPI_GAP, ST_I2C_START, ST_I2C_BIT, ST_I2C_STOP
  } state_t;

  state_t state; // Transfer sequencer
  cfg_t cfg; // Protocol and strap settings
  logic [6:0] reg_addr; // Codec register to access
  logic [7:0] wdata; // Byte to write
  logic [7:0] rdata; // Last byte read back
  logic op_read; // Current transfer is a read
  logic nack; // Slave refused a byte
  logic done; // Transfer finished
  logic page; // Page last selected through address 0
  logic [3:0] div_cnt; // Quarter-bit divider
  logic [1:0] phase; // Quarter within a bit
  logic [4:0] bit_cnt; // Bit within frame or byte
  logic [1:0] byte_idx; // I2C byte within transaction
  logic [6:0] wait_cnt; // Reset hold and select gap
  logic [15:0] tx; // Outgoing bits, MSB first
  logic [15:0] rx; // Incoming bits
  logic ss_n; // SPI slave select
  logic sclk; // SPI serial clock
  logic mosi; // SPI data out
  logic miso_s1, miso_s2; // MISO synchroniser
  logic sda_s1, sda_s2; // SDA synchroniser

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire idle = (state == ST_IDLE);
  wire busy = !idle;
  wire wr_ctrl = bus_req.wr && (bus_req.addr == REG_CTRL);
  wire wr_addr = bus_req.wr && (bus_req.addr == REG_ADDR);
  wire wr_wdata = bus_req.wr && (bus_req.addr == REG_WDATA);
  wire wr_status = bus_req.wr && (bus_req.addr == REG_STATUS);
  wire wr_cfg = bus_req.wr && (bus_req.addr == REG_CFG);
  wire go = wr_ctrl && bus_req.wdata[CTRL_GO] && idle;
  wire go_read = bus_req.wdata[CTRL_READ];
  wire [3:0] qtr_lim = cfg.spi ? SPI_QTR_LIM : I2C_QTR_LIM;
  wire tick = (div_cnt == qtr_lim);
  wire ph_end = tick && (phase == PH_LAST);
  // General call is write only, so it never turns into a read
  wire i2c_read = op_read && !cfg.gcall;
  wire [6:0] dev_addr = {I2C_ADDR_HI, cfg.adr1, cfg.adr0}; // R15
  wire [7:0] dev_wr = cfg.gcall ? GCALL_BYTE : {dev_addr, 1'b0}; // R19
  wire [7:0] dev_rd = {dev_addr, 1'b1};
  wire [7:0] spi_cmd = {reg_addr, go_read}; // R05
  wire [7:0] spi_second = go_read ? SPI_DUMMY : wdata; // R06
  wire i2c_byte_end = (state == ST_I2C_BIT) && ph_end && (bit_cnt == I2C_LAST_BIT);
  wire spi_frame_end = (state == ST_SPI_BIT) && ph_end && (bit_cnt == SPI_LAST_BIT);
  wire slave_nack = i2c_byte_end && (byte_idx != IDX_RD_DATA) && rx[0]; // R18
  wire i2c_fin = (state == ST_I2C_STOP) && ph_end;
  wire spi_fin = (state == ST_SPI_GAP) && (wait_cnt == SS_GAP_LIM);
  wire finish = i2c_fin || spi_fin;
  wire page_hit = !op_read && (reg_addr == PAGE_SELECT_ADDR) && !cfg.gcall; // R08
  wire [7:0] status = {4'h0, page, done, nack, busy};
  wire [7:0] ctrl_rd = {6'h00, op_read, busy};
  wire [7:0] read_mux =
    (bus_req.addr == REG_CTRL) ? ctrl_rd :
    (bus_req.addr == REG_ADDR) ? {1'b0, reg_addr} :
    (bus_req.addr == REG_WDATA) ? wdata :
    (bus_req.addr == REG_RDATA) ? rdata :
    (bus_req.addr == REG_STATUS) ? status :
    (bus_req.addr == REG_CFG) ? {4'h0, cfg} : BYTE_ZERO;

  // Open-drain lines: the low level is the only one ever driven
  assign scl_out = 1'b0; // R16
  assign sda_out = 1'b0; // R16

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins come from outside the ref_clk domain; only stage two is read
  always_ff @(posedge ref_clk) begin
    miso_s1 <= multifunction_pin_c;
    miso_s2 <= miso_s1;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Settings and strap only change while idle so the strap stays stable
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg <= CFG_RESET;
      reg_addr <= ADDR_RESET;
      wdata <= BYTE_ZERO;
    end else begin
      if (wr_cfg && idle) begin
        cfg <= bus_req.wdata[3:0]; // R23
      end
      if (wr_addr && idle) begin
        reg_addr <= bus_req.wdata[6:0];
      end
      if (wr_wdata && idle) begin
        wdata <= bus_req.wdata; // R22
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data <= BYTE_ZERO;
    end else begin
      rd_data <= bus_req.rd ? read_mux : BYTE_ZERO;
    end
  end

  // Sticky flags: a completion in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      if (finish) begin
        done <= 1'b1;
      end else if (go || (wr_status && bus_req.wdata[STAT_DONE])) begin
        done <= 1'b0;
      end
      if (slave_nack) begin
        nack <= 1'b1;
      end else if (go || (wr_status && bus_req.wdata[STAT_NACK])) begin
        nack <= 1'b0;
      end
    end
  end

  // Page tracker follows completed writes to the page-select address
  always_ff @(posedge ref_clk) begin
    if (!rst_b || state == ST_RESET) begin
      page <= 1'b0; // R09
    end else if (finish && page_hit && !nack && !slave_nack) begin
      page <= wdata[0]; // R10
    end
  end

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Divider restarts with each transfer so the first quarter is full
  always_ff @(posedge ref_clk) begin
    if (!rst_b || idle || state == ST_RESET || state == ST_SPI_GAP) begin
      div_cnt <= 4'h0;
      phase <= PH_DRIVE;
    end else begin
      div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
      phase <= tick ? phase + 2'h1 : phase;
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // The strap-select and multifunction pins share the SPI roles
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      select_strap <= 1'b0;
      codec_reset_n <= 1'b0;
      multifunction_pin_a <= 1'b0;
      multifunction_pin_b <= 1'b0;
      multifunction_pin_d <= 1'b0;
    end else begin
      select_strap <= cfg.spi; // R14
      codec_reset_n <= (state != ST_RESET); // R24
      multifunction_pin_a <= cfg.spi ? ss_n : cfg.adr0; // R15
      multifunction_pin_b <= cfg.spi ? sclk : cfg.adr1; // R15
      multifunction_pin_d <= mosi;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // One register per frame: no bursts, so page ends are never crossed
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= ST_RESET;
      op_read <= 1'b0;
      rdata <= BYTE_ZERO;
      bit_cnt <= 5'h00;
      byte_idx <= IDX_DEV_WR;
      wait_cnt <= 7'h00;
      tx <= {SPI_DUMMY, SPI_DUMMY};
      rx <= {SPI_DUMMY, SPI_DUMMY};
      ss_n <= 1'b1;
      sclk <= 1'b0; // R01
      mosi <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        // Codec reset held low for the minimum pulse
        ST_RESET: begin
          wait_cnt <= wait_cnt + 7'h01;
          if (wait_cnt == RESET_HOLD_LIM) begin
            state <= ST_IDLE; // R24
          end
        end
        // Frame setup from the latched registers
        ST_IDLE: begin
          wait_cnt <= 7'h00;
          bit_cnt <= 5'h00;
          byte_idx <= IDX_DEV_WR;
          if (go) begin
            op_read <= go_read;
            if (cfg.spi) begin
              tx <= {spi_cmd, spi_second}; // R04
              ss_n <= 1'b0; // R01
              state <= ST_SPI_BIT;
            end else begin
              tx <= {dev_wr, 1'b1, TX_PAD};
              state <= ST_I2C_START;
            end
          end
        end
        // Full-duplex SPI bit: drive on rising edge, sample on falling
        ST_SPI_BIT: begin
          if (tick && phase == PH_DRIVE) begin
            sclk <= 1'b1;
            mosi <= tx[15]; // R02
          end
          if (tick && phase == PH_MID) begin
            sclk <= 1'b0; // R01
            rx <= {rx[14:0], miso_s2}; // R03
          end
          if (ph_end) begin
            tx <= {tx[14:0], 1'b0}; // R25
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (spi_frame_end) begin
            ss_n <= 1'b1; // R12
            mosi <= 1'b0;
            rdata <= op_read ? rx[7:0] : rdata; // R07
            state <= ST_SPI_GAP;
          end
        end
        // Select stays high long enough before the next frame may start
        ST_SPI_GAP: begin
          wait_cnt <= wait_cnt + 7'h01;
          if (spi_fin) begin
            state <= ST_IDLE; // R11
          end
        end
        // START or repeated START: SDA falls while SCL is high
        ST_I2C_START: begin
          if (tick && phase == PH_DRIVE) begin
            sda_oe <= 1'b0;
          end
          if (tick && phase == PH_RISE) begin
            scl_oe <= 1'b0;
          end
          if (tick && phase == PH_MID) begin
            sda_oe <= 1'b1; // R17
          end
          if (ph_end) begin
            scl_oe <= 1'b1;
            bit_cnt <= 5'h00;
            state <= ST_I2C_BIT;
          end
        end
        // Nine clocks per byte; the ninth is the acknowledge slot
        ST_I2C_BIT: begin
          if (tick && phase == PH_DRIVE) begin
            sda_oe <= !tx[15]; // R16
          end
          if (tick && phase == PH_RISE) begin
            scl_oe <= 1'b0;
          end
          if (tick && phase == PH_MID) begin
            rx <= {rx[14:0], sda_s2};
          end
          if (ph_end) begin
            scl_oe <= 1'b1;
            tx <= {tx[14:0], 1'b1}; // R25
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (i2c_byte_end) begin
            bit_cnt <= 5'h00;
            if (slave_nack) begin
              state <= ST_I2C_STOP; // R18
            end else if (byte_idx == IDX_RD_DATA) begin
              rdata <= rx[8:1];
              state <= ST_I2C_STOP; // R26
            end else if (byte_idx == IDX_DEV_WR && !cfg.gcall) begin
              byte_idx <= IDX_REG;
              tx <= {1'b0, reg_addr, 1'b1, TX_PAD};
            end else if (byte_idx == IDX_DEV_WR || (byte_idx == IDX_REG && !i2c_read)) begin
              byte_idx <= IDX_THIRD;
              tx <= {wdata, 1'b1, TX_PAD}; // R20
            end else if (byte_idx == IDX_REG) begin
              byte_idx <= IDX_THIRD;
              tx <= {dev_rd, 1'b1, TX_PAD};
              state <= ST_I2C_START; // R17
            end else if (i2c_read) begin
              byte_idx <= IDX_RD_DATA;
              tx <= {I2C_RELEASE, 1'b1, TX_PAD}; // R26
            end else begin
              state <= ST_I2C_STOP;
            end
          end
        end
        // STOP: SDA rises while SCL is high, then the bus is idle
        ST_I2C_STOP: begin
          if (tick && phase == PH_DRIVE) begin
            sda_oe <= 1'b1;
          end
          if (tick && phase == PH_RISE) begin
            scl_oe <= 1'b0;
          end
          if (tick && phase == PH_MID) begin
            sda_oe <= 1'b0; // R17
          end
          if (ph_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== tb/codec_port_model.sv
// Behavioural codec control port: SPI or I2C slave on a paged map.
`timescale 1ns/10ps
module codec_port_model (
  input wire logic rst_n,
  input wire logic strap,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_d,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic mute,
  output logic pin_c,
  output logic sda_wire
);
  logic [7:0] mem [0:255]; // Two pages of 128
  logic page;
  logic [7:0] sh, cmd, txd;
  logic [6:0] ptr;
  logic [4:0] cnt;
  logic [3:0] bits;
  logic [1:0] idx;
  logic act, gc, rdm, tx, pull;
  wire scl_wire = ~scl_oe; // Pull-up
  assign sda_wire = ~(sda_oe | pull);
  function automatic logic [7:0] peek(input logic [6:0] a);
    peek = (a == 7'h00) ? {7'h00, page} : mem[{page, a}];
  endfunction
  task automatic poke(input logic [6:0] a, input logic [7:0] d);
    if (a == 7'h00) page = d[0];
    else mem[{page, a}] = d;
  endtask
  initial pin_c = 1'b0;
  always @(negedge rst_n) begin
    page = 1'b0; pull = 1'b0; tx = 1'b0; act = 1'b0; rdm = 1'b0; bits = 4'h0;
  end
  // SPI side, strap high; unselected MISO toggles as a floating line would
  always @(negedge pin_a) cnt = 5'h00;
  always @(posedge pin_a) pin_c = ~pin_c;
  always @(posedge pin_b) if (strap && !pin_a) begin
    txd = peek(cmd[7:1]);
    if (cnt >= 5'd8 && cnt < 5'd16 && cmd[0]) pin_c = txd[15 - cnt];
    else pin_c = ~pin_c;
  end
  always @(negedge pin_b) if (strap && !pin_a) begin
    sh = {sh[6:0], pin_d};
    cnt = cnt + 5'h01;
    if (cnt == 5'd8) cmd = sh;
    if (cnt == 5'd16 && !cmd[0]) poke(cmd[7:1], sh);
  end
  // I2C side, strap low
  always @(negedge sda_wire) if (!strap && scl_wire) begin
    bits = 4'h0; idx = 2'h0; tx = 1'b0;
  end
  always @(posedge sda_wire) if (!strap && scl_wire) act = 1'b0;
  always @(posedge scl_wire) if (!strap) begin
    if (bits < 4'd8) begin
      sh = {sh[6:0], sda_wire};
      bits = bits + 4'h1;
    end else begin
      bits = 4'h0;
      if (tx && sda_wire) begin
        tx = 1'b0; act = 1'b0;
      end else if (tx) begin
        ptr = ptr + 7'h01; txd = peek(ptr);
      end else if (rdm) begin
        tx = 1'b1; rdm = 1'b0; txd = peek(ptr);
      end
    end
  end
  always @(negedge scl_wire) if (!strap) begin
    if (bits == 4'd8 && !tx) begin
      if (idx == 2'h0) begin
        gc = (sh == 8'h00);
        act = !mute && (gc || sh[7:1] == {5'b00110, pin_b, pin_a});
        rdm = act && sh[0];
      end else if (act && idx == 2'h1 && !gc) ptr = sh[6:0];
      else if (act && !gc) begin
        poke(ptr, sh); ptr = ptr + 7'h01;
      end
      if (idx != 2'h3) idx = idx + 2'h1;
      pull = act;
    end else if (tx && bits != 4'd8) pull = ~txd[7 - bits];
    else pull = 1'b0;
  end
endmodule

// ===== tb/dual_serial_host_props.sv
// Pin-level checker for the codec control-port host.
`timescale 1ns/10ps
module dual_serial_host_props
  import ctrl_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire ctrl_port_pkg::bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic select_strap,
  input wire logic codec_reset_n,
  input wire logic multifunction_pin_a,
  input wire logic multifunction_pin_b,
  input wire logic multifunction_pin_c,
  input wire logic multifunction_pin_d,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  localparam int GAP_MIN = SS_GAP_CYC;
  logic [6:0] gap; // Select-high cycles, saturating
  logic [4:0] sck_cnt; // SCLK rises in this frame
  logic spi_q; // Strap one cycle ago
  // Saturate outside SPI so a mode switch never looks like a short gap
  always_ff @(posedge ref_clk) begin
    spi_q <= select_strap;
    if (!rst_b || !select_strap) gap <= 7'h7F;
    else if (!multifunction_pin_a) gap <= 7'h00;
    else if (gap != 7'h7F) gap <= gap + 7'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b || multifunction_pin_a) sck_cnt <= 5'h00;
    else if ($rose(multifunction_pin_b)) sck_cnt <= sck_cnt + 5'h01;
  end
  sequence sclk_high_s;
    multifunction_pin_b [*4] ##1 !multifunction_pin_b;
  endsequence
  sequence scl_high_s;
    !scl_oe [*8];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_SCLK_IDLE: assert property (select_strap && spi_q && multifunction_pin_a
    |-> !multifunction_pin_b) else $error("SCLK high while deselected");
  AST_SCLK_PULSE: assert property (select_strap && !multifunction_pin_a
    && $rose(multifunction_pin_b) |-> sclk_high_s) else $error("SCLK pulse length");
  AST_MOSI_EDGE: assert property (select_strap && !multifunction_pin_a
    && $changed(multifunction_pin_d) |-> $rose(multifunction_pin_b))
    else $error("MOSI moved off the rising edge");
  AST_FRAME_BITS: assert property (select_strap && spi_q && $rose(multifunction_pin_a)
    |-> sck_cnt == 5'd16) else $error("Frame not 16 clocks");
  AST_SS_GAP: assert property (select_strap && $fell(multifunction_pin_a)
    |-> int'(gap) >= GAP_MIN) else $error("Select gap too short");
  AST_PULL_ONLY: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("Bus line driven high");
  AST_START_SCL: assert property (!select_strap && $rose(sda_oe) && !scl_oe
    |-> ##[1:8] scl_oe) else $error("No clock after start");
  AST_STOP_IDLE: assert property (!select_strap && $fell(sda_oe) && !scl_oe
    |=> !scl_oe) else $error("Clock pulled after stop");
  AST_SCL_HIGH: assert property (!select_strap && $fell(scl_oe) |-> scl_high_s)
    else $error("SCL high too short");
  AST_CODEC_RST: assert property ($rose(rst_b) |-> !codec_reset_n ##[1:3] codec_reset_n)
    else $error("Codec reset pulse");
endmodule
bind dual_serial_host dual_serial_host_props dual_serial_host_props_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
  .select_strap(select_strap), .codec_reset_n(codec_reset_n),
  .multifunction_pin_a(multifunction_pin_a), .multifunction_pin_b(multifunction_pin_b),
  .multifunction_pin_c(multifunction_pin_c), .multifunction_pin_d(multifunction_pin_d),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// ===== tb/dual_serial_host_tb.sv
// Self-checking bench for the codec control-port host.
`timescale 1ns/10ps
module dual_serial_host_tb;
  import ctrl_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  bus_req_t bus_req = '0;
  logic mute = 1'b0; // Codec ignores its address
  logic [7:0] rd_data, st, rv;
  logic select_strap, codec_reset_n, pin_a, pin_b, pin_c, pin_d, scl_oe, sda_oe, sda_wire;
  int n_fail = 0;
  int checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  dual_serial_host dual_serial_host_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .select_strap(select_strap), .codec_reset_n(codec_reset_n),
    .multifunction_pin_a(pin_a), .multifunction_pin_b(pin_b), .multifunction_pin_c(pin_c),
    .multifunction_pin_d(pin_d), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_wire),
    .sda_out(), .sda_oe(sda_oe)
  );
  codec_port_model codec_port_model_i (
    .rst_n(codec_reset_n), .strap(select_strap), .pin_a(pin_a), .pin_b(pin_b),
    .pin_d(pin_d), .scl_oe(scl_oe), .sda_oe(sda_oe), .mute(mute), .pin_c(pin_c),
    .sda_wire(sda_wire)
  );
  // One-cycle write strobe, then a idle cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    // Taken at the edge that closes the data cycle, before it is cleared
    @(posedge ref_clk);
    d = rd_data;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded poll: a frame that never ends leaves done low and fails
  task automatic wait_done();
    int n;
    n = 0;
    st = 8'h00;
    while (st[STAT_DONE] !== 1'b1 && n < 3000) begin
      rd(REG_STATUS, st);
      n++;
    end
    // A poll limit that runs out is a mismatch of its own
    if (st[STAT_DONE] !== 1'b1) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, st, 8'h04);
    end
  endtask
  task automatic go(input logic op_rd, input logic [6:0] ra, input logic [7:0] wd);
    wr(REG_ADDR, {1'b0, ra});
    wr(REG_WDATA, wd);
    wr(REG_CTRL, {6'h00, op_rd, 1'b1});
    wait_done();
    rd(REG_RDATA, rv);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(REG_STATUS, st);
    chk(st & 8'h0F, 8'h00);
    rd(4'hF, st);
    chk(st, 8'h00);
    $display("test reset done");
    wr(REG_CFG, 8'h01);
    go(1'b0, 7'h05, 8'hA5);
    chk(st & 8'h0F, 8'h04);
    go(1'b1, 7'h05, 8'h00);
    chk(rv, 8'hA5);
    go(1'b0, 7'h00, 8'h01);
    chk(st & 8'h0F, 8'h0C);
    go(1'b1, 7'h00, 8'h00);
    chk(rv, 8'h01);
    go(1'b0, 7'h05, 8'h3C);
    go(1'b1, 7'h05, 8'h00);
    chk(rv, 8'h3C);
    go(1'b0, 7'h00, 8'h00);
    go(1'b1, 7'h05, 8'h00);
    chk(rv, 8'hA5);
    wr(REG_CTRL, 8'h01);
    wr(REG_CFG, 8'h00);
    rd(REG_CFG, st);
    chk(st & 8'h0F, 8'h01);
    rd(REG_CTRL, st);
    chk(st, 8'h01);
    rd(REG_ADDR, st);
    chk(st, 8'h05);
    wait_done();
    $display("test spi done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_CFG, {5'h00, i[1:0], 1'b0});
      go(1'b0, 7'(8 + i), 8'h5A ^ 8'(i));
      chk(st & 8'h07, 8'h04);
      go(1'b1, 7'(8 + i), 8'h00);
      chk(rv, 8'h5A ^ 8'(i));
    end
    mute <= 1'b1;
    go(1'b0, 7'h09, 8'h11);
    chk(st & 8'h07, 8'h06);
    mute <= 1'b0;
    wr(REG_STATUS, 8'h06);
    rd(REG_STATUS, st);
    chk(st & 8'h07, 8'h00);
    wr(REG_CFG, 8'h08);
    go(1'b0, 7'h00, 8'h77);
    chk(st & 8'h0F, 8'h04);
    $display("test i2c done");
    finish_test();
  end
  // Watchdog, well past the expected run time
  initial begin
    #6_000_000;
    n_fail++;
    finish_test();
  end
endmodule
